/* src/addr_former.sv */
/*
  Forms the effective address from a short or full direct address.
  Assumes the caller registers the result.
*/
`timescale 1ns/1ps
`include "lsu_defs.svh"
module addr_former (
  input wire logic short_addr,
  input wire logic [31:0] addr_in,
  output logic [23:0] phys_addr
);
  logic [31:0] eff;

  // Short form sign-extends: low half to bottom block, high half to top block
  always_comb begin
    if (short_addr) begin
      eff = {{16{addr_in[`SHORT_SIGN_BIT]}}, addr_in[15:0]};
    end else begin
      eff = addr_in;
    end
    phys_addr = eff[`PHYS_ADDR_W-1:0];
  end
endmodule

/* src/data_resizer.sv */
/*
  Zero or sign extension of short values into a full register word.
  Assumes sizes come from lsu_pkg.
*/
`timescale 1ns/1ps
`include "lsu_defs.svh"
module data_resizer (
  input wire lsu_pkg::size_sel_e size,
  input wire logic [31:0] raw,
  output logic [31:0] register_widen_instruction
);
  // Raw holds the value right-aligned
  always_comb begin
    unique case (size)
      lsu_pkg::SZ_UNSIGNED_BYTE: register_widen_instruction = {24'h00_0000, raw[7:0]};
      lsu_pkg::SZ_SIGNED_BYTE: register_widen_instruction = {{24{raw[`BYTE_SIGN_BIT]}}, raw[7:0]};
      lsu_pkg::SZ_UNSIGNED_HALF: register_widen_instruction = {16'h0000, raw[15:0]};
      lsu_pkg::SZ_SIGNED_HALF: register_widen_instruction = {{16{raw[`HALF_SIGN_BIT]}}, raw[15:0]};
      default: register_widen_instruction = raw;
    endcase
  end
endmodule

/* src/lsu_defs.svh */
/*
  Constants of the load/store operand path: sizes, field positions, reset values.
  Assumes it is included by bare name from the package and the design modules.
*/
`ifndef LSU_DEFS_SVH
`define LSU_DEFS_SVH
`define REG_COUNT 16
`define REG_IDX_W 4
`define DATA_W 32
`define ADDR_W 32
`define PHYS_ADDR_W 24
`define SHORT_ADDR_W 16
`define SHORT_SIGN_BIT 15
`define BYTE_SIGN_BIT 7
`define HALF_SIGN_BIT 15
`define REG_RESET_VAL 32'h0000_0000
`define ADDR_RESET_VAL 32'h0000_0000
`endif

/* src/lsu_pkg.sv */
/*
  Types for the load/store operand path.
  Assumes lsu_defs.svh is reachable on the include path.
*/
`include "lsu_defs.svh"
package lsu_pkg;
  // Size and extension selection from the decoder
  typedef enum logic [2:0] {
    SZ_QUAD = 3'h0,
    SZ_UNSIGNED_BYTE = 3'h1,
    SZ_SIGNED_BYTE = 3'h2,
    SZ_UNSIGNED_HALF = 3'h3,
    SZ_SIGNED_HALF = 3'h4
  } size_sel_e;

  // Operation selection; one-hot
  typedef enum logic [4:0] {
    OP_MOVE = 5'h01,
    OP_LOAD = 5'h02,
    OP_STORE = 5'h04,
    OP_WIDEN = 5'h08,
    OP_PAIR = 5'h10
  } op_e;

  // One decoded request
  typedef struct packed {
    op_e op;
    size_sel_e size;
    logic [3:0] dst;
    logic [3:0] src;
    logic short_addr;
    logic [31:0] addr;
  } req_s;

  // Memory side request
  typedef struct packed {
    logic valid;
    logic write;
    logic [23:0] addr;
    logic [3:0] lane_en;
    logic [31:0] wdata;
  } mem_req_s;
endpackage

/* src/operand_path.sv */
/*
  Load/store operand path: work registers, address forming, byte mapping.
  Assumes a decoder issues one request per cycle and memory answers reads
  combinationally in the cycle after the request, big-endian bytes in rdata.
*/
`timescale 1ns/1ps
`include "lsu_defs.svh"
module operand_path (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic req_valid,
  input wire lsu_pkg::req_s req,
  input wire logic [31:0] mem_rdata,
  output lsu_pkg::mem_req_s mem_q,
  output logic [63:0] pair_q,
  output logic [31:0] src_val_q,
  output logic done_q
);
  // ----------------------------------------
  // Storage
  // ----------------------------------------
  logic [31:0] regs_q [`REG_COUNT];
  logic load_pend_q;
  logic [3:0] load_dst_q;
  lsu_pkg::size_sel_e load_size_q;
  logic [23:0] phys_addr;
  logic [31:0] load_raw;
  logic [31:0] load_ext;
  logic [31:0] widen_ext;
  logic [31:0] src_val;

  assign src_val = regs_q[req.src];

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  // Bytes moved for a size selection
  function automatic logic [3:0] lanes(input lsu_pkg::size_sel_e s);
    unique case (s)
      lsu_pkg::SZ_UNSIGNED_BYTE, lsu_pkg::SZ_SIGNED_BYTE: lanes = 4'h1;
      lsu_pkg::SZ_UNSIGNED_HALF, lsu_pkg::SZ_SIGNED_HALF: lanes = 4'h3;
      default: lanes = 4'hF;
    endcase
  endfunction

  addr_former u_addr (
    .short_addr(req.short_addr),
    .addr_in(req.addr),
    .phys_addr(phys_addr)
  );

  // Memory bytes come most significant first; right-align by size
  always_comb begin
    unique case (load_size_q)
      lsu_pkg::SZ_UNSIGNED_BYTE, lsu_pkg::SZ_SIGNED_BYTE:
        load_raw = {24'h00_0000, mem_rdata[31:24]};
      lsu_pkg::SZ_UNSIGNED_HALF, lsu_pkg::SZ_SIGNED_HALF:
        load_raw = {16'h0000, mem_rdata[31:16]};
      default: load_raw = mem_rdata;
    endcase
  end

  data_resizer u_load_ext (
    .size(load_size_q),
    .raw(load_raw),
    .register_widen_instruction(load_ext)
  );

  data_resizer u_widen_ext (
    .size(req.size),
    .raw(src_val),
    .register_widen_instruction(widen_ext)
  );

  // ----------------------------------------
  // Register file writes
  // ----------------------------------------
  // A returning load and a new move may both write; the load lands last
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      for (int i = 0; i < `REG_COUNT; i++) begin
        regs_q[i] <= `REG_RESET_VAL;
      end
    end else begin
      if (req_valid && req.op == lsu_pkg::OP_MOVE) begin
        regs_q[req.dst] <= src_val;
      end
      if (req_valid && req.op == lsu_pkg::OP_WIDEN) begin
        regs_q[req.dst] <= widen_ext;
      end
      if (load_pend_q) begin
        regs_q[load_dst_q] <= load_ext;
      end
    end
  end

  // ----------------------------------------
  // Memory request
  // ----------------------------------------
  // Store data left-aligned so the top lane hits the effective address
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      mem_q <= '0;
    end else begin
      mem_q.valid <= req_valid &&
        (req.op == lsu_pkg::OP_LOAD || req.op == lsu_pkg::OP_STORE);
      mem_q.write <= req_valid && req.op == lsu_pkg::OP_STORE;
      mem_q.addr <= phys_addr;
      mem_q.lane_en <= lanes(req.size);
      unique case (lanes(req.size))
        4'h1: mem_q.wdata <= {src_val[7:0], 24'h00_0000};
        4'h3: mem_q.wdata <= {src_val[15:0], 16'h0000};
        default: mem_q.wdata <= src_val;
      endcase
    end
  end

  // Load bookkeeping for the returning cycle
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      load_pend_q <= 1'b0;
      load_dst_q <= 4'h0;
      load_size_q <= lsu_pkg::SZ_QUAD;
    end else begin
      load_pend_q <= req_valid && req.op == lsu_pkg::OP_LOAD;
      load_dst_q <= req.dst;
      load_size_q <= req.size;
    end
  end

  // ----------------------------------------
  // Pair operand and source view
  // ----------------------------------------
  // Pair is dst (high) and dst+1 (low), read for the wide divide
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      pair_q <= 64'h0;
      src_val_q <= `REG_RESET_VAL;
      done_q <= 1'b0;
    end else begin
      if (req_valid && req.op == lsu_pkg::OP_PAIR) begin
        pair_q <= {regs_q[req.dst], regs_q[4'(req.dst + 4'h1)]};
      end
      src_val_q <= src_val;
      done_q <= req_valid;
    end
  end

  // ----------------------------------------
  // Checks: address forming
  // ----------------------------------------
  // The short form splits between the bottom block and the top block
  short_high_a: assert property (@(posedge mclk) disable iff (!reset_n)
    req_valid && req.short_addr && req.addr[15] && req.op == lsu_pkg::OP_LOAD
    |=> mem_q.addr[23:16] == 8'hFF)
    else $error("short high address not mapped to top block");

  short_low_a: assert property (@(posedge mclk) disable iff (!reset_n)
    req_valid && req.short_addr && !req.addr[15] && req.op == lsu_pkg::OP_LOAD
    |=> mem_q.addr[23:16] == 8'h00)
    else $error("short low address not mapped to bottom block");

  short_offset_a: assert property (@(posedge mclk) disable iff (!reset_n)
    req_valid && req.short_addr
    |=> mem_q.addr[15:0] == $past(req.addr[15:0]))
    else $error("short address low half altered");

  full_addr_a: assert property (@(posedge mclk) disable iff (!reset_n)
    req_valid && !req.short_addr
    |=> mem_q.addr == $past(req.addr[23:0]))
    else $error("full address not cut to 24 bits");

  // ----------------------------------------
  // Checks: memory request
  // ----------------------------------------
  // Only loads and stores reach memory; a move stays inside the core
  move_no_mem_a: assert property (@(posedge mclk) disable iff (!reset_n)
    req_valid && (req.op == lsu_pkg::OP_MOVE || req.op == lsu_pkg::OP_WIDEN)
    |=> !mem_q.valid)
    else $error("register move reached memory");

  load_read_a: assert property (@(posedge mclk) disable iff (!reset_n)
    req_valid && req.op == lsu_pkg::OP_LOAD
    |=> mem_q.valid && !mem_q.write)
    else $error("load not issued as a read");

  done_pulse_a: assert property (@(posedge mclk) disable iff (!reset_n)
    req_valid |=> done_q)
    else $error("request not acknowledged");

  idle_quiet_a: assert property (@(posedge mclk) disable iff (!reset_n)
    !req_valid |=> !done_q && !mem_q.valid)
    else $error("idle cycle produced a request");

  // ----------------------------------------
  // Checks: stores
  // ----------------------------------------
  // Store data is left-aligned so the top lane lands at the effective address
  quad_lanes_a: assert property (@(posedge mclk) disable iff (!reset_n)
    req_valid && req.op == lsu_pkg::OP_STORE && req.size == lsu_pkg::SZ_QUAD
    |=> mem_q.lane_en == 4'hF && mem_q.wdata == $past(src_val))
    else $error("quad store wrong");

  byte_store_a: assert property (@(posedge mclk) disable iff (!reset_n)
    req_valid && req.op == lsu_pkg::OP_STORE
    && (req.size == lsu_pkg::SZ_UNSIGNED_BYTE || req.size == lsu_pkg::SZ_SIGNED_BYTE)
    |=> mem_q.wdata[31:24] == $past(src_val[7:0]) && mem_q.lane_en == 4'h1)
    else $error("byte store wrong");

  half_store_a: assert property (@(posedge mclk) disable iff (!reset_n)
    req_valid && req.op == lsu_pkg::OP_STORE
    && (req.size == lsu_pkg::SZ_UNSIGNED_HALF || req.size == lsu_pkg::SZ_SIGNED_HALF)
    |=> mem_q.wdata[31:16] == $past(src_val[15:0]) && mem_q.lane_en == 4'h3)
    else $error("half store wrong");

  store_keeps_src_a: assert property (@(posedge mclk) disable iff (!reset_n)
    req_valid && req.op == lsu_pkg::OP_STORE && !load_pend_q
    |=> regs_q[$past(req.src)] == $past(src_val))
    else $error("store altered its source register");

  // ----------------------------------------
  // Checks: loads
  // ----------------------------------------
  // Loads land one edge after the memory cycle, right-aligned and extended
  quad_load_a: assert property (@(posedge mclk) disable iff (!reset_n)
    load_pend_q && load_size_q == lsu_pkg::SZ_QUAD
    |=> regs_q[$past(load_dst_q)] == $past(mem_rdata))
    else $error("quad load not big-endian");

  ubyte_load_a: assert property (@(posedge mclk) disable iff (!reset_n)
    load_pend_q && load_size_q == lsu_pkg::SZ_UNSIGNED_BYTE
    |=> regs_q[$past(load_dst_q)] == {24'h00_0000, $past(mem_rdata[31:24])})
    else $error("unsigned byte load wrong");

  sbyte_ext_a: assert property (@(posedge mclk) disable iff (!reset_n)
    load_pend_q && load_size_q == lsu_pkg::SZ_SIGNED_BYTE
    |-> load_ext[31:8] == {24{mem_rdata[31]}})
    else $error("signed byte extension wrong");

  uhalf_ext_a: assert property (@(posedge mclk) disable iff (!reset_n)
    load_pend_q && load_size_q == lsu_pkg::SZ_UNSIGNED_HALF
    |-> load_ext == {16'h0000, mem_rdata[31:16]})
    else $error("unsigned half load wrong");

  shalf_ext_a: assert property (@(posedge mclk) disable iff (!reset_n)
    load_pend_q && load_size_q == lsu_pkg::SZ_SIGNED_HALF
    |-> load_ext == {{16{mem_rdata[31]}}, mem_rdata[31:16]})
    else $error("signed half extension wrong");

  signed_value_a: assert property (@(posedge mclk) disable iff (!reset_n)
    load_pend_q && load_size_q == lsu_pkg::SZ_SIGNED_BYTE
    |-> $signed(load_ext) == $signed(mem_rdata[31:24]))
    else $error("signed byte value changed");

  load_quad_lanes_a: assert property (@(posedge mclk) disable iff (!reset_n)
    req_valid && req.op == lsu_pkg::OP_LOAD && req.size == lsu_pkg::SZ_QUAD
    |=> mem_q.lane_en == 4'hF)
    else $error("quad load lanes wrong");

  load_byte_lanes_a: assert property (@(posedge mclk) disable iff (!reset_n)
    req_valid && req.op == lsu_pkg::OP_LOAD
    && (req.size == lsu_pkg::SZ_UNSIGNED_BYTE || req.size == lsu_pkg::SZ_SIGNED_BYTE)
    |=> mem_q.lane_en == 4'h1)
    else $error("byte load lanes wrong");

  load_half_lanes_a: assert property (@(posedge mclk) disable iff (!reset_n)
    req_valid && req.op == lsu_pkg::OP_LOAD
    && (req.size == lsu_pkg::SZ_UNSIGNED_HALF || req.size == lsu_pkg::SZ_SIGNED_HALF)
    |=> mem_q.lane_en == 4'h3)
    else $error("half load lanes wrong");

  // ----------------------------------------
  // Checks: register moves
  // ----------------------------------------
  // Guarded against a landing load, which takes priority on its edge
  move_full_a: assert property (@(posedge mclk) disable iff (!reset_n)
    req_valid && req.op == lsu_pkg::OP_MOVE && !load_pend_q
    |=> regs_q[$past(req.dst)] == $past(src_val))
    else $error("register move lost bits");

  widen_a: assert property (@(posedge mclk) disable iff (!reset_n)
    req_valid && req.op == lsu_pkg::OP_WIDEN && req.size == lsu_pkg::SZ_SIGNED_HALF
    && !load_pend_q
    |=> regs_q[$past(req.dst)][31:16] == {16{$past(src_val[15])}})
    else $error("register widen wrong");

  widen_zero_a: assert property (@(posedge mclk) disable iff (!reset_n)
    req_valid && req.op == lsu_pkg::OP_WIDEN && req.size == lsu_pkg::SZ_UNSIGNED_BYTE
    && !load_pend_q
    |=> regs_q[$past(req.dst)] == {24'h00_0000, $past(src_val[7:0])})
    else $error("unsigned byte widen wrong");

  widen_sbyte_a: assert property (@(posedge mclk) disable iff (!reset_n)
    req_valid && req.op == lsu_pkg::OP_WIDEN && req.size == lsu_pkg::SZ_SIGNED_BYTE
    && !load_pend_q
    |=> regs_q[$past(req.dst)] == {{24{$past(src_val[7])}}, $past(src_val[7:0])})
    else $error("signed byte widen wrong");

  widen_uhalf_a: assert property (@(posedge mclk) disable iff (!reset_n)
    req_valid && req.op == lsu_pkg::OP_WIDEN && req.size == lsu_pkg::SZ_UNSIGNED_HALF
    && !load_pend_q
    |=> regs_q[$past(req.dst)] == {16'h0000, $past(src_val[15:0])})
    else $error("unsigned half widen wrong");

  pair_read_a: assert property (@(posedge mclk) disable iff (!reset_n)
    req_valid && req.op == lsu_pkg::OP_PAIR
    |=> pair_q == {$past(regs_q[req.dst]), $past(regs_q[4'(req.dst + 4'h1)])})
    else $error("register pair read wrong");

  pair_hold_a: assert property (@(posedge mclk) disable iff (!reset_n)
    !(req_valid && req.op == lsu_pkg::OP_PAIR) |=> $stable(pair_q))
    else $error("register pair changed without request");
endmodule

/* tb/load_store_operand_sizing_tb.sv */
/*
  Self-checking bench for the operand path: loads, address forming, stores, moves.
  Assumes mem_model answers reads; registers are seen through quad stores.
*/
`timescale 1ns/1ps
module load_store_operand_sizing_tb;
  logic mclk, reset_n, req_valid, done_q;
  lsu_pkg::req_s req;
  lsu_pkg::mem_req_s mem_q;
  logic [31:0] mem_rdata, src_val_q;
  logic [63:0] pair_q;
  int fails = 0;
  int compares = 0;

  operand_path operand_path_inst (.mclk(mclk), .reset_n(reset_n), .req_valid(req_valid),
    .req(req), .mem_rdata(mem_rdata), .mem_q(mem_q), .pair_q(pair_q),
    .src_val_q(src_val_q), .done_q(done_q));
  mem_model mem_model_inst (.mclk(mclk), .mem_q(mem_q), .mem_rdata(mem_rdata));

  // ----------------
  // Helpers
  // ----------------
  always #5 mclk = ~mclk;

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One request for one cycle; returns once the registered answer is visible
  task automatic issue(input lsu_pkg::op_e op, input lsu_pkg::size_sel_e sz,
                       input logic [3:0] d, input logic [3:0] s, input logic sh,
                       input logic [31:0] ad);
    @(posedge mclk);
    req_valid <= 1'h1;
    req <= '{op, sz, d, s, sh, ad};
    @(posedge mclk);
    req_valid <= 1'h0;
    #1;
  endtask

  // Register contents are read back through a quad store; src_val_q and pair_q also show them
  task automatic dump(input logic [3:0] r, output logic [31:0] v);
    issue(lsu_pkg::OP_STORE, lsu_pkg::SZ_QUAD, 4'h0, r, 1'h0, 32'hF0);
    v = mem_q.wdata;
  endtask

  function automatic logic [31:0] word_at(input logic [7:0] a);
    return {a ^ 8'hA5, (a + 8'h01) ^ 8'hA5, (a + 8'h02) ^ 8'hA5, (a + 8'h03) ^ 8'hA5};
  endfunction

  function automatic logic [31:0] register_widen_instruction(input int k, input logic [31:0] v);
    case (k)
      1: return {24'h0, v[7:0]};
      2: return {{24{v[7]}}, v[7:0]};
      3: return {16'h0, v[15:0]};
      4: return {{16{v[15]}}, v[15:0]};
      default: return v;
    endcase
  endfunction

  // ----------------
  // Scenarios
  // ----------------
  task automatic test_loads;
    logic [31:0] v, w;
    logic [7:0] a;
    for (int j = 0; j < 2; j++) begin
      for (int k = 0; k < 5; k++) begin
        a = j ? 8'h90 : 8'h10;
        w = word_at(a);
        issue(lsu_pkg::OP_LOAD, lsu_pkg::size_sel_e'(k), 4'h1, 4'h0, 1'h0, {24'h0, a});
        chk(mem_q.lane_en, k == 0 ? 4'hF : k < 3 ? 4'h1 : 4'h3);
        dump(4'h1, v);
        chk(v, register_widen_instruction(k, k == 0 ? w : k < 3 ? w >> 24 : w >> 16));
      end
    end
    $display("test_loads done");
  endtask

  task automatic test_addr;
    issue(lsu_pkg::OP_LOAD, lsu_pkg::SZ_QUAD, 4'h4, 4'h0, 1'h1, 32'h1234_7FF0);
    chk(mem_q.addr, 24'h007FF0);
    chk({mem_q.valid, mem_q.write, done_q}, 3'h5);
    issue(lsu_pkg::OP_LOAD, lsu_pkg::SZ_QUAD, 4'h4, 4'h0, 1'h1, 32'h5555_8010);
    chk(mem_q.addr, 24'hFF8010);
    issue(lsu_pkg::OP_LOAD, lsu_pkg::SZ_QUAD, 4'h4, 4'h0, 1'h0, 32'hAB12_3456);
    chk(mem_q.addr, 24'h123456);
    $display("test_addr done");
  endtask

  task automatic test_stores;
    logic [31:0] v, r2;
    r2 = word_at(8'h20);
    issue(lsu_pkg::OP_LOAD, lsu_pkg::SZ_QUAD, 4'h2, 4'h0, 1'h0, 32'h20);
    issue(lsu_pkg::OP_STORE, lsu_pkg::SZ_UNSIGNED_BYTE, 4'h0, 4'h2, 1'h0, 32'h40);
    chk({mem_q.write, mem_q.lane_en, mem_q.wdata[31:24]}, {1'h1, 4'h1, r2[7:0]});
    issue(lsu_pkg::OP_STORE, lsu_pkg::SZ_SIGNED_HALF, 4'h0, 4'h2, 1'h0, 32'h44);
    chk({mem_q.lane_en, mem_q.wdata[31:16]}, {4'h3, r2[15:0]});
    issue(lsu_pkg::OP_STORE, lsu_pkg::SZ_QUAD, 4'h0, 4'h2, 1'h0, 32'h48);
    chk({mem_q.lane_en, mem_q.wdata}, {4'hF, r2});
    issue(lsu_pkg::OP_LOAD, lsu_pkg::SZ_UNSIGNED_BYTE, 4'h5, 4'h0, 1'h0, 32'h40);
    dump(4'h5, v);
    chk(v, {24'h0, r2[7:0]});
    issue(lsu_pkg::OP_LOAD, lsu_pkg::SZ_UNSIGNED_HALF, 4'h5, 4'h0, 1'h0, 32'h44);
    dump(4'h5, v);
    chk(v, {16'h0, r2[15:0]});
    issue(lsu_pkg::OP_LOAD, lsu_pkg::SZ_QUAD, 4'h5, 4'h0, 1'h0, 32'h48);
    dump(4'h5, v);
    chk(v, r2);
    dump(4'h2, v);
    chk({v, src_val_q}, {r2, r2});
    $display("test_stores done");
  endtask

  // Widen works in place, so the source is copied afresh before each size
  task automatic test_moves;
    logic [31:0] v, r2;
    r2 = word_at(8'h20);
    issue(lsu_pkg::OP_MOVE, lsu_pkg::SZ_QUAD, 4'hF, 4'h2, 1'h0, 32'h0);
    dump(4'hF, v);
    chk(v, r2);
    for (int k = 1; k < 5; k++) begin
      issue(lsu_pkg::OP_MOVE, lsu_pkg::SZ_QUAD, 4'h3, 4'h2, 1'h0, 32'h0);
      issue(lsu_pkg::OP_WIDEN, lsu_pkg::size_sel_e'(k), 4'h3, 4'h3, 1'h0, 32'h0);
      dump(4'h3, v);
      chk(v, register_widen_instruction(k, r2));
    end
    issue(lsu_pkg::OP_PAIR, lsu_pkg::SZ_QUAD, 4'hF, 4'h0, 1'h0, 32'h0);
    chk(pair_q, {r2, 32'h0});
    $display("test_moves done");
  endtask

  // Every register takes a load and hands it back through a store
  task automatic test_regs;
    logic [31:0] v;
    logic [7:0] a;
    for (int r = 0; r < 16; r++) begin
      a = 8'h80 + 8'(r * 4);
      issue(lsu_pkg::OP_LOAD, lsu_pkg::SZ_QUAD, 4'(r), 4'h0, 1'h0, {24'h0, a});
    end
    for (int r = 0; r < 16; r++) begin
      dump(4'(r), v);
      chk(v, word_at(8'h80 + 8'(r * 4)));
    end
    $display("test_regs done");
  endtask

  // ----------------
  // Run control
  // ----------------
  task automatic tally_and_finish;
    $display("compares=%0d fails=%0d", compares, fails);
    if (fails == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // Main sequence after ten cycles of reset
  initial begin
    mclk = 1'h0;
    reset_n = 1'h0;
    req_valid = 1'h0;
    req = '0;
    repeat (10) @(posedge mclk);
    reset_n <= 1'h1;
    test_loads;
    test_addr;
    test_stores;
    test_moves;
    test_regs;
    tally_and_finish;
  end

  // Watchdog far beyond the roughly 170 cycles the tests need
  initial begin
    #(5000 * 10);
    fails++;
    tally_and_finish;
  end
endmodule

/* tb/mem_model.sv */
/*
  Memory partner: a 256-byte image with big-endian lanes, reads answered in the request cycle.
  Assumes operand_path drives mem_q and samples mem_rdata at the next edge.
*/
`timescale 1ns/1ps
module mem_model (
  input wire logic mclk,
  input wire lsu_pkg::mem_req_s mem_q,
  output logic [31:0] mem_rdata
);
  // ----------------
  // Byte image
  // ----------------
  logic [7:0] img [256];
  logic [31:0] last_q;
  logic [7:0] a;
  int n;

  // Fixed pattern; the bench derives the same bytes on its own
  initial begin
    last_q = 32'h0;
    for (int i = 0; i < 256; i++) img[i] = 8'(i) ^ 8'hA5;
  end
  assign a = mem_q.addr[7:0];
  // Idle bus shows the inverse of the last word, so stale data cannot match
  always_comb begin
    if (mem_q.valid && !mem_q.write) mem_rdata = {img[a], img[a + 8'h01], img[a + 8'h02],
                                                  img[a + 8'h03]};
    else mem_rdata = ~last_q;
  end
  // Writes land lane by lane, top byte at the effective address
  always @(posedge mclk) begin
    last_q <= mem_rdata;
    n = (mem_q.lane_en == 4'hF) ? 4 : (mem_q.lane_en == 4'h3) ? 2 : 1;
    if (mem_q.valid && mem_q.write) begin
      for (int k = 0; k < n; k++) img[a + 8'(k)] <= mem_q.wdata[31 - 8 * k -: 8];
    end
  end
endmodule
